// [rtl/irq_route_pkg.sv]
// ****************************************************************
// register map and field layout
// ****************************************************************
package irq_route_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int NSRC = 32;

    localparam logic [7:0] OFF_DIRECTION = 8'h58;
    localparam logic [7:0] OFF_TRIGGER_HI = 8'h60;
    localparam logic [7:0] OFF_MAILBOX0 = 8'h70;

    localparam logic [31:0] DIRECTION_RESET = 32'h00000000;
    localparam logic [31:0] MAILBOX_RESET = 32'h00000000;
    // writable direction bits; the rest are fixed
    localparam logic [31:0] DIR_WRITABLE = 32'hff0f8f0f;
    // direction bits that are fixed to the pci side
    localparam logic [31:0] DIR_FIXED_PCI = 32'h00102000;
    // direction bits that are fixed to the local side
    localparam logic [31:0] DIR_FIXED_LOCAL = 32'h00e05000;

    // source positions, shared by direction, enable and pending vectors
    localparam int BIT_PCI_ERRLOG = 31;
    localparam int BIT_LOCAL_ERRLOG = 30;
    localparam int BIT_MASTER_PARITY = 29;
    localparam int BIT_CFG_STATUS = 28;
    localparam int BIT_DMA_LOCAL_ERR = 27;
    localparam int BIT_DMA_PCI_ERR = 26;
    localparam int BIT_DMA_RESET = 25;
    localparam int BIT_DMA_DONE = 24;
    localparam int BIT_PCI_IRQ_IN = 23;
    localparam int BIT_LOCAL_IRQ_IN = 20;
    localparam int BIT_MAILBOX0 = 16;
    localparam int BIT_LOCAL_PARITY = 15;
    localparam int BIT_OUT_POST_NONEMPTY = 13;
    localparam int BIT_IN_FREE_EMPTY = 11;
    localparam int BIT_SOFT_IRQ3 = 3;
    localparam int BIT_SOFT_IRQ2 = 2;
    localparam int BIT_SOFT_IRQ0 = 0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [rtl/irq_route.sv]
`timescale 1ns/1ps
`default_nettype none
module irq_route #(
    parameter int ADDR_W = irq_route_pkg::ADDR_W
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // enable and status bits from the interrupt control and status registers
    input wire logic [31:0] irq_enable,
    input wire logic [31:0] irq_pending,
    // soft irq 1 and 0 trigger writes of 1, one-cycle pulses
    input wire logic [1:0] soft_irq_lo_trigger,
    // flag set pulses towards the status register, bit n sets soft irq n
    output logic [3:0] soft_irq_flag_set,
    // routed interrupt outputs
    output logic local_irq,
    output logic pci_irq
);

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge = (old & ~m) | (val & m);
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    logic aw_held_q, aw_held_d;
    logic w_held_q, w_held_d;
    logic [ADDR_W-1:0] waddr_q, waddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic arready_q, arready_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] dir_q, dir_d;
    logic [31:0] mbox_q, mbox_d;
    logic [3:0] soft_set_q, soft_set_d;
    logic local_irq_q, pci_irq_q;
    wire [31:0] route_dir;

    // ****************************************************************
    // write channel
    // ****************************************************************
    wire aw_take = awvalid && awready_q;
    wire w_take = wvalid && wready_q;
    // one write under way: commit once both halves are held
    wire do_write = aw_held_q && w_held_q && !bvalid_q;
    wire wr_dir = do_write && hit(waddr_q, irq_route_pkg::OFF_DIRECTION);
    wire wr_trig = do_write && hit(waddr_q, irq_route_pkg::OFF_TRIGGER_HI);
    wire wr_mbox = do_write && hit(waddr_q, irq_route_pkg::OFF_MAILBOX0);
    wire wr_known = wr_dir || wr_trig || wr_mbox;

    assign aw_held_d = aw_held_q ? !do_write : aw_take;
    assign w_held_d = w_held_q ? !do_write : w_take;
    assign waddr_d = aw_take ? awaddr : waddr_q;
    assign wdata_d = w_take ? wdata : wdata_q;
    assign wstrb_d = w_take ? wstrb : wstrb_q;
    assign bvalid_d = do_write || (bvalid_q && !bready);
    assign bresp_d = do_write ? (wr_known ? irq_route_pkg::RESP_OKAY
                                          : irq_route_pkg::RESP_SLVERR) : bresp_q;
    // ready drops while a half is held or the response waits
    assign awready_d = !aw_held_d && !bvalid_d;
    assign wready_d = !w_held_d && !bvalid_d;

    // fixed bits never store; only writable positions take data
    assign dir_d = wr_dir ? (merge(dir_q, wdata_q, wstrb_q) & irq_route_pkg::DIR_WRITABLE)
                          : dir_q;
    assign mbox_d = wr_mbox ? merge(mbox_q, wdata_q, wstrb_q) : mbox_q;

    // trigger bits store nothing: a written 1 becomes a one-cycle set pulse
    assign soft_set_d[irq_route_pkg::BIT_SOFT_IRQ3] =
        wr_trig && wstrb_q[0] && wdata_q[irq_route_pkg::BIT_SOFT_IRQ3];
    assign soft_set_d[irq_route_pkg::BIT_SOFT_IRQ2] =
        wr_trig && wstrb_q[0] && wdata_q[irq_route_pkg::BIT_SOFT_IRQ2];
    assign soft_set_d[1:0] = soft_irq_lo_trigger;

    // ****************************************************************
    // read channel
    // ****************************************************************
    wire ar_take = arvalid && arready_q;
    wire rd_dir = hit(araddr, irq_route_pkg::OFF_DIRECTION);
    wire rd_trig = hit(araddr, irq_route_pkg::OFF_TRIGGER_HI);
    wire rd_mbox = hit(araddr, irq_route_pkg::OFF_MAILBOX0);
    wire [31:0] rd_value = rd_dir ? route_dir : (rd_mbox ? mbox_q : 32'h00000000);

    assign rvalid_d = ar_take || (rvalid_q && !rready);
    assign arready_d = !rvalid_d;
    // trigger register always reads zero
    assign rdata_d = ar_take ? rd_value : rdata_q;
    assign rresp_d = ar_take ? ((rd_dir || rd_trig || rd_mbox) ? irq_route_pkg::RESP_OKAY
                                                              : irq_route_pkg::RESP_SLVERR)
                             : rresp_q;

    // ****************************************************************
    // routing
    // ****************************************************************
    // fixed positions forced regardless of the stored value
    assign route_dir = (dir_q & irq_route_pkg::DIR_WRITABLE)
                     | irq_route_pkg::DIR_FIXED_PCI;
    // a disabled source is dropped before the direction is looked at
    wire [31:0] live = irq_pending & irq_enable;
    // route 0 selects the local side, route 1 the pci side
    wire local_d = |(live & ~route_dir);
    wire pci_d = |(live & route_dir);

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            waddr_q <= '0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= irq_route_pkg::RESP_OKAY;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= irq_route_pkg::RESP_OKAY;
        end else begin
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_q <= irq_route_pkg::DIRECTION_RESET;
            mbox_q <= irq_route_pkg::MAILBOX_RESET;
            soft_set_q <= 4'h0;
            local_irq_q <= 1'b0;
            pci_irq_q <= 1'b0;
        end else begin
            dir_q <= dir_d;
            mbox_q <= mbox_d;
            soft_set_q <= soft_set_d;
            local_irq_q <= local_d;
            pci_irq_q <= pci_d;
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign soft_irq_flag_set = soft_set_q;
    assign local_irq = local_irq_q;
    assign pci_irq = pci_irq_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    localparam int P = irq_route_pkg::BIT_PCI_ERRLOG;
    localparam int Q = irq_route_pkg::BIT_LOCAL_ERRLOG;
    localparam int M = irq_route_pkg::BIT_MAILBOX0;
    localparam int S = irq_route_pkg::BIT_SOFT_IRQ0;
    localparam int LI = irq_route_pkg::BIT_LOCAL_IRQ_IN;
    localparam int PI = irq_route_pkg::BIT_PCI_IRQ_IN;
    localparam int MP = irq_route_pkg::BIT_MASTER_PARITY;
    localparam int CS = irq_route_pkg::BIT_CFG_STATUS;
    localparam int DN = irq_route_pkg::BIT_DMA_DONE;
    localparam int LP = irq_route_pkg::BIT_LOCAL_PARITY;
    localparam int FE = irq_route_pkg::BIT_IN_FREE_EMPTY;

    property p_pel_local;
        @(posedge aclk) disable iff (!aresetn)
        irq_pending[P] && irq_enable[P] && !dir_q[P] |=> local_irq_q;
    endproperty
    a_pel_local: assert property (p_pel_local) else $error("pel not local");

    property p_qel_pci;
        @(posedge aclk) disable iff (!aresetn)
        irq_pending[Q] && irq_enable[Q] && dir_q[Q] |=> pci_irq_q;
    endproperty
    a_qel_pci: assert property (p_qel_pci) else $error("qel not pci");

    property p_fixed_read;
        @(posedge aclk) disable iff (!aresetn)
        ar_take && rd_dir |=> (rdata_q & irq_route_pkg::DIR_FIXED_LOCAL) == 32'h00000000
                              && (rdata_q & irq_route_pkg::DIR_FIXED_PCI)
                                 == irq_route_pkg::DIR_FIXED_PCI;
    endproperty
    a_fixed_read: assert property (p_fixed_read) else $error("fixed route wrong");

    property p_pci_in_local;
        @(posedge aclk) disable iff (!aresetn)
        irq_pending == (32'h1 << PI) && irq_enable[PI] |=> local_irq_q && !pci_irq_q;
    endproperty
    a_pci_in_local: assert property (p_pci_in_local) else $error("pci in not local");

    property p_local_in_pci;
        @(posedge aclk) disable iff (!aresetn)
        irq_pending == (32'h1 << LI) && irq_enable[LI] |=> pci_irq_q && !local_irq_q;
    endproperty
    a_local_in_pci: assert property (p_local_in_pci) else $error("local in not pci");

    property p_mb_route;
        @(posedge aclk) disable iff (!aresetn)
        wr_dir && wstrb_q[2] |=> route_dir[M] == $past(wdata_q[M]);
    endproperty
    a_mb_route: assert property (p_mb_route) else $error("mailbox route not stored");

    property p_si_route;
        @(posedge aclk) disable iff (!aresetn)
        wr_dir && wstrb_q[0] |=> route_dir[S] == $past(wdata_q[S]);
    endproperty
    a_si_route: assert property (p_si_route) else $error("soft route not stored");

    property p_gate;
        @(posedge aclk) disable iff (!aresetn)
        (irq_pending & irq_enable) == 32'h00000000 |=> !local_irq_q && !pci_irq_q;
    endproperty
    a_gate: assert property (p_gate) else $error("disabled source routed");

    property p_trig3;
        @(posedge aclk) disable iff (!aresetn)
        wr_trig && wstrb_q[0] && wdata_q[3] |=> soft_irq_flag_set[3] ##1 !soft_irq_flag_set[3];
    endproperty
    a_trig3: assert property (p_trig3) else $error("trigger 3 pulse wrong");

    property p_trig2_zero;
        @(posedge aclk) disable iff (!aresetn)
        !(wr_trig && wdata_q[2]) |=> !soft_irq_flag_set[2];
    endproperty
    a_trig2_zero: assert property (p_trig2_zero) else $error("spurious trigger 2");

    property p_trig_lo;
        @(posedge aclk) disable iff (!aresetn)
        soft_irq_lo_trigger[0] |=> soft_irq_flag_set[0];
    endproperty
    a_trig_lo: assert property (p_trig_lo) else $error("trigger 0 lost");

    property p_mbox_read;
        @(posedge aclk) disable iff (!aresetn)
        ar_take && rd_mbox |=> rvalid_q && rdata_q == $past(mbox_q);
    endproperty
    a_mbox_read: assert property (p_mbox_read) else $error("mailbox read mismatch");

    property p_bresp_bound;
        @(posedge aclk) disable iff (!aresetn)
        do_write |=> bvalid_q;
    endproperty
    a_bresp_bound: assert property (p_bresp_bound) else $error("no write response");

    property p_mpar_local;
        @(posedge aclk) disable iff (!aresetn)
        irq_pending[MP] && irq_enable[MP] && !dir_q[MP] |=> local_irq_q;
    endproperty
    a_mpar_local: assert property (p_mpar_local) else $error("mpar not local");

    property p_cfg_pci;
        @(posedge aclk) disable iff (!aresetn)
        irq_pending[CS] && irq_enable[CS] && dir_q[CS] |=> pci_irq_q;
    endproperty
    a_cfg_pci: assert property (p_cfg_pci) else $error("cfg status not pci");

    property p_done_pci;
        @(posedge aclk) disable iff (!aresetn)
        irq_pending[DN] && irq_enable[DN] && dir_q[DN] |=> pci_irq_q;
    endproperty
    a_done_pci: assert property (p_done_pci) else $error("dma done not pci");

    property p_lpar_pci;
        @(posedge aclk) disable iff (!aresetn)
        irq_pending[LP] && irq_enable[LP] && dir_q[LP] |=> pci_irq_q;
    endproperty
    a_lpar_pci: assert property (p_lpar_pci) else $error("local parity not pci");

    property p_list_route;
        @(posedge aclk) disable iff (!aresetn)
        wr_dir && wstrb_q[1] |=> route_dir[FE] == $past(wdata_q[FE]);
    endproperty
    a_list_route: assert property (p_list_route) else $error("list route not stored");

    property p_any_local;
        @(posedge aclk) disable iff (!aresetn)
        (irq_pending & irq_enable & ~route_dir) != 32'h00000000 |=> local_irq_q;
    endproperty
    a_any_local: assert property (p_any_local) else $error("local output missed");

    property p_any_pci;
        @(posedge aclk) disable iff (!aresetn)
        (irq_pending & irq_enable & route_dir) != 32'h00000000 |=> pci_irq_q;
    endproperty
    a_any_pci: assert property (p_any_pci) else $error("pci output missed");

    c_mbox_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_mbox);
    c_trig3: cover property (@(posedge aclk) disable iff (!aresetn) soft_set_q[3]);
    c_both: cover property (@(posedge aclk) disable iff (!aresetn) local_irq_q && pci_irq_q);
    c_unmapped: cover property (@(posedge aclk) disable iff (!aresetn)
        rvalid_q && rresp_q == irq_route_pkg::RESP_SLVERR);

endmodule // irq_route
`default_nettype wire

// [verif/irq_status_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// enable and status registers outside the router
// ****************************************************************
module irq_status_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bench controls
    input wire logic [31:0] enable_set,
    input wire logic [31:0] source_level,
    input wire logic flag_clear,
    // router side
    input wire logic [3:0] soft_irq_flag_set,
    output logic [31:0] irq_enable,
    output logic [31:0] irq_pending,
    output logic [3:0] soft_flags
);
    logic [3:0] flags_q;
    logic [3:0] flags_d;
    // a set pulse in the clear cycle wins, so no trigger is ever lost
    assign flags_d = (flag_clear ? 4'h0 : flags_q) | soft_irq_flag_set;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_q <= 4'h0;
        end else begin
            flags_q <= flags_d;
        end
    end
    assign irq_enable = enable_set;
    assign irq_pending = source_level | {28'h0, flags_q};
    assign soft_flags = flags_q;
endmodule // irq_status_model
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, enable_set = 32'h0, source_level = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] soft_irq_lo_trigger = 2'h0;
    logic flag_clear = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, local_irq, pci_irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, irq_enable, irq_pending;
    logic [3:0] soft_irq_flag_set, soft_flags;
    int mismatches = 0;
    int checks_done = 0;
    always #2 aclk = ~aclk;
    irq_route dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .irq_enable(irq_enable), .irq_pending(irq_pending),
        .soft_irq_lo_trigger(soft_irq_lo_trigger), .soft_irq_flag_set(soft_irq_flag_set),
        .local_irq(local_irq), .pci_irq(pci_irq));
    irq_status_model far_side (.aclk(aclk), .aresetn(aresetn), .enable_set(enable_set),
        .source_level(source_level), .flag_clear(flag_clear),
        .soft_irq_flag_set(soft_irq_flag_set), .irq_enable(irq_enable),
        .irq_pending(irq_pending), .soft_flags(soft_flags));
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (mismatches == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // master waits on the answer only; the watchdog ends a hang
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (1'b1) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                bready <= 1'b0;
                chk("write response", {30'h0, bresp}, {30'h0, er});
                break;
            end
        end
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (1'b1) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rready <= 1'b0;
                chk(what, rdata, e);
                chk("read response", {30'h0, rresp}, {30'h0, er});
                break;
            end
        end
    endtask
    task automatic reset_and_check();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rchk("direction reset", irq_route_pkg::OFF_DIRECTION, 32'h00102000, 2'h0);
        rchk("mailbox reset", irq_route_pkg::OFF_MAILBOX0, 32'h0, 2'h0);
        rchk("trigger reads zero", irq_route_pkg::OFF_TRIGGER_HI, 32'h0, 2'h0);
    endtask
    // one source at a time, masked then enabled, against the read-back route
    task automatic route(input logic [31:0] pat);
        logic [31:0] dv;
        int i;
        dv = (pat & irq_route_pkg::DIR_WRITABLE) | irq_route_pkg::DIR_FIXED_PCI;
        wr(irq_route_pkg::OFF_DIRECTION, pat, 4'hf, 2'h0);
        rchk("direction", irq_route_pkg::OFF_DIRECTION, dv, 2'h0);
        for (i = 0; i < 32; i++) begin
            if (i < 4 || i > 7) begin
                enable_set <= ~(32'h1 << i);
                source_level <= 32'h1 << i;
                repeat (3) @(posedge aclk);
                chk("masked", {30'h0, local_irq, pci_irq}, 32'h0);
                enable_set <= 32'h1 << i;
                repeat (3) @(posedge aclk);
                chk("local irq", 32'(local_irq), 32'(!dv[i]));
                chk("pci irq", {31'h0, pci_irq}, {31'h0, dv[i]});
            end
        end
        enable_set <= 32'h0;
        source_level <= 32'h0;
    endtask
    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        reset_and_check();
        route(32'hffffffff);
        route(32'h00000000);
        route(32'h5a5a5a5a);
        wr(irq_route_pkg::OFF_TRIGGER_HI, 32'h0, 4'h1, 2'h0);
        @(posedge aclk);
        chk("soft flags", {28'h0, soft_flags}, 32'h0);
        wr(irq_route_pkg::OFF_TRIGGER_HI, 32'h8, 4'h1, 2'h0);
        @(posedge aclk);
        chk("soft flags", {28'h0, soft_flags}, 32'h8);
        wr(irq_route_pkg::OFF_TRIGGER_HI, 32'h4, 4'h1, 2'h0);
        @(posedge aclk);
        chk("soft flags", {28'h0, soft_flags}, 32'hc);
        rchk("trigger reads zero", irq_route_pkg::OFF_TRIGGER_HI, 32'h0, 2'h0);
        soft_irq_lo_trigger <= 2'h1;
        @(posedge aclk);
        soft_irq_lo_trigger <= 2'h2;
        @(posedge aclk);
        soft_irq_lo_trigger <= 2'h0;
        repeat (3) @(posedge aclk);
        chk("soft flags", {28'h0, soft_flags}, 32'hf);
        flag_clear <= 1'b1;
        @(posedge aclk);
        flag_clear <= 1'b0;
        wr(irq_route_pkg::OFF_MAILBOX0, 32'ha5c31e77, 4'hf, 2'h0);
        rchk("mailbox", irq_route_pkg::OFF_MAILBOX0, 32'ha5c31e77, 2'h0);
        wr(irq_route_pkg::OFF_MAILBOX0, 32'h0000ff00, 4'h2, 2'h0);
        rchk("mailbox lane", irq_route_pkg::OFF_MAILBOX0, 32'ha5c3ff77, 2'h0);
        // unmapped place answers an error and leaves the registers alone
        wr(8'h44, 32'hffffffff, 4'hf, irq_route_pkg::RESP_SLVERR);
        rchk("unmapped", 8'h44, 32'h0, irq_route_pkg::RESP_SLVERR);
        rchk("mailbox kept", irq_route_pkg::OFF_MAILBOX0, 32'ha5c3ff77, 2'h0);
        reset_and_check();
        chk("flags after reset", {28'h0, soft_flags}, 32'h0);
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
